// ===== verification/link_node_model.sv
/*
 far-side node of one router link: sends one code per link clock pulse.
 assumes the router samples these lines with its own clock.
*/
`timescale 1ns/100ps
module link_node_model (
   output logic link_clk_o,
   output logic [7:0] code_o,
   output logic [1:0] kind_o,
   output logic [4:0] src_o
);
   initial begin
      link_clk_o = 1'h0;
      {code_o, kind_o, src_o} = 15'h0000;
   end
   // ---------------
   // one code frame
   // ---------------
   // clock idles low between frames; lines flip after so stale data never looks valid
   task automatic send(input logic [7:0] c, input logic [1:0] k, input logic [4:0] s);
      code_o = c;
      kind_o = k;
      src_o = s;
      #24 link_clk_o = 1'h1;
      #24 link_clk_o = 1'h0;
      {code_o, kind_o, src_o} = ~{c, k, s};
   endtask
endmodule

// ===== verification/tb_router_port_control_two.sv
/*
 self-checking bench for the router port control block.
 assumes default parameters and the link node model on the link pins.
*/
`timescale 1ns/100ps
module tb_router_port_control_two;
   logic REF_CLK_I, RESET_N_I, REG_WR_I, REG_RD_I, REG_ACK_O, TICK_I, RT_REQ_I, CODE_READY_I;
   logic RT_VALID_O, RT_USE_MAP_O, LINK_CLK_I, LINK_READY_O, CODE_VALID_O;
   logic [11:0] REG_ADDR_I;
   logic [31:0] REG_WDATA_I, REG_RDATA_O, seed, ctl[20];
   logic [9:0] STRAP_RELOAD_I;
   logic [19:0] PKT_ACTIVE_I, PKT_MOVE_I, PKT_OVERRUN_I, SPILL_O, STATIC_EN_I, CODE_DEST_O, sp;
   logic [4:0] RT_PORT_I, LINK_SRC_I;
   logic [7:0] RT_FIRST_I, RT_ADDR_O, LINK_CODE_I, CODE_O;
   logic [1:0] LINK_KIND_I, CODE_KIND_O;
   logic [29:0] q[$];
   int bad_count, tests_run;

   router_port_control_two dut_u (
      .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
      .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O),
      .STRAP_RELOAD_I(STRAP_RELOAD_I), .TICK_I(TICK_I), .PKT_ACTIVE_I(PKT_ACTIVE_I), .PKT_MOVE_I(PKT_MOVE_I),
      .PKT_OVERRUN_I(PKT_OVERRUN_I), .SPILL_O(SPILL_O), .STATIC_EN_I(STATIC_EN_I), .RT_REQ_I(RT_REQ_I),
      .RT_PORT_I(RT_PORT_I), .RT_FIRST_I(RT_FIRST_I), .RT_VALID_O(RT_VALID_O), .RT_ADDR_O(RT_ADDR_O),
      .RT_USE_MAP_O(RT_USE_MAP_O), .LINK_CLK_I(LINK_CLK_I), .LINK_CODE_I(LINK_CODE_I),
      .LINK_KIND_I(LINK_KIND_I), .LINK_SRC_I(LINK_SRC_I), .LINK_READY_O(LINK_READY_O),
      .CODE_VALID_O(CODE_VALID_O), .CODE_READY_I(CODE_READY_I), .CODE_O(CODE_O), .CODE_KIND_O(CODE_KIND_O),
      .CODE_DEST_O(CODE_DEST_O)
   );
   link_node_model pm (.link_clk_o(LINK_CLK_I), .code_o(LINK_CODE_I), .kind_o(LINK_KIND_I), .src_o(LINK_SRC_I));

   initial begin
      REF_CLK_I = 1'h0;
      forever #2.5 REF_CLK_I = ~REF_CLK_I;
   end

   // --------------
   // helpers
   // --------------
   function automatic logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
   endfunction
   function automatic logic [31:0] rv(input int p);
      return p ? 32'hC000_DE00 : 32'hC000_8000;
   endfunction
   function automatic logic [11:0] ca(input int p);
      return p ? 12'(12'h984 + 4 * (p - 1)) : 12'h980;
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(negedge REF_CLK_I);
      REG_WR_I = w;
      REG_RD_I = !w;
      REG_ADDR_I = a;
      REG_WDATA_I = d;
      @(negedge REF_CLK_I);
      REG_WR_I = 1'h0;
      REG_RD_I = 1'h0;
      chk("ack", REG_ACK_O, 1);
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
      acc(1'h0, a, 0);
      chk(n, REG_RDATA_O, e);
   endtask
   task automatic wctl(input int p, input logic [31:0] d);
      acc(1'h1, ca(p), d);
      ctl[p] = d & (p ? 32'hFFFF_DE3F : 32'hFFFF_8000);
   endtask
   task automatic tick;
      @(negedge REF_CLK_I);
      TICK_I = 1'h1;
      @(negedge REF_CLK_I);
      TICK_I = 1'h0;
      repeat (3) @(negedge REF_CLK_I);
   endtask
   // reload 2: a move after the first tick restarts, so only the third tick expires
   task automatic trun(input int p, input logic o);
      logic e;
      e = o ? ctl[p][15] : ctl[p][14];
      PKT_OVERRUN_I[p] = o;
      PKT_ACTIVE_I[p] = 1'h1;
      sp = 0;
      for (int i = 0; i < 3; i++) begin
         tick;
         if (i == 0)
            PKT_MOVE_I[p] = 1'h1;
         @(negedge REF_CLK_I);
         PKT_MOVE_I[p] = 1'h0;
         chk("spill", sp[p], i == 2 ? e : 1'h0);
      end
      PKT_ACTIVE_I[p] = 1'h0;
      rd("tflag", 12'(12'h880 + 4 * p), {13'h0000, e, 18'h0_0000});
      acc(1'h1, 12'(12'h880 + 4 * p), 32'h0004_0000);
   endtask
   // model of filter, truncation and the two-entry buffer
   task automatic code(input logic [7:0] c, input logic [1:0] k, input logic [4:0] s);
      logic [19:0] d;
      logic ok;
      for (int j = 0; j < 20; j++)
         d[j] = j != s && (k == 0 || ctl[j][k == 1 ? 10 : 12]);
      ok = !(k == 1 && !ctl[s][9]) && !(k == 3 && !ctl[s][11]) && q.size() < 2;
      if (ok)
         q.push_back({c, k, d});
      sp = 0;
      pm.send(c, k, s);
      repeat (4) @(negedge REF_CLK_I);
      chk("trunc", sp[4], k != 3 && ((c ^ ctl[4][23:16]) & ctl[4][31:24]) == 0);
      chk("cfg trunc", sp[0], k != 3 && ((c ^ ctl[0][23:16]) & ctl[0][31:24]) == 0);
   endtask
   task automatic drain;
      for (int i = 0; i < 40 && q.size() > 0; i++)
         @(negedge REF_CLK_I);
      if (q.size() > 0) begin
         bad_count++;
         results;
      end
   endtask

   always @(posedge REF_CLK_I) begin
      sp = sp | SPILL_O;
      if (CODE_VALID_O === 1'h1 && CODE_READY_I) begin
         if (q.size() == 0)
            chk("extra code", 1, 0);
         else
            chk("code", {CODE_O, CODE_KIND_O, CODE_DEST_O}, q.pop_front());
      end
   end

   // --------------
   // main sequence
   // --------------
   initial begin
      {REG_WR_I, REG_RD_I, TICK_I, RT_REQ_I, RESET_N_I} = 5'h00;
      {REG_ADDR_I, REG_WDATA_I, RT_PORT_I, RT_FIRST_I} = 57'h0;
      {PKT_ACTIVE_I, PKT_MOVE_I, PKT_OVERRUN_I, STATIC_EN_I, sp} = 100'h0;
      CODE_READY_I = 1'h1;
      seed = 32'h6729_dff3;
      STRAP_RELOAD_I = seed[9:0];
      for (int p = 0; p < 20; p++)
         ctl[p] = rv(p);
      repeat (8) @(negedge REF_CLK_I);
      RESET_N_I = 1'h1;
      repeat (6) @(negedge REF_CLK_I);
      rd("rld rst", 12'h94C, {22'h0, STRAP_RELOAD_I});
      rd("unmapped", 12'hFFC, 0);
      for (int p = 0; p < 2; p++) begin
         rd("ctl rst", ca(p), rv(p));
         wctl(p, 32'hFFFF_FFFF);
         rd("ctl ro", ca(p), ctl[p]);
         wctl(p, rv(p));
      end
      acc(1'h1, 12'h900, 0);
      rd("rld min", 12'h900, 1);
      seed = lf(seed);
      acc(1'h1, 12'h908, seed);
      rd("rld", 12'h908, seed[9:0] ? {22'h0, seed[9:0]} : 1);
      for (int p = 0; p < 4; p += 3) begin
         acc(1'h1, 12'(12'h900 + 4 * p), 2);
         for (int e = 0; e < 2; e++) begin
            if (e)
               wctl(p, rv(p) & 32'hFF00_2FFF);
            for (int o = 0; o < 2; o++)
               trun(p, o[0]);
         end
         wctl(p, rv(p));
      end
      PKT_ACTIVE_I = 20'h0_0011;
      wctl(2, 32'hC000_D400);
      wctl(5, 32'hC000_CA00);
      for (int i = 0; i < 12; i++) begin
         seed = lf(seed);
         code(i < 6 ? seed[7:0] & 8'h3F : seed[7:0], i % 3 == 2 ? 3 : i % 3, i % 2 ? 2 : seed[12:8] % 19 + 1);
         drain;
      end
      rd("trunc flag4", 12'h890, 32'h1000_0000);
      rd("trunc flag0", 12'h880, 32'h1000_0000);
      CODE_READY_I = 1'h0;
      for (int i = 0; i < 3; i++)
         code(8'(8'h80 + i), 0, 1);
      chk("full", LINK_READY_O, 0);
      CODE_READY_I = 1'h1;
      drain;
      wctl(7, 32'hC000_DE27);
      STATIC_EN_I = 20'h0_0080;
      for (int p = 7; p < 9; p++) begin
         seed = lf(seed);
         @(negedge REF_CLK_I);
         RT_REQ_I = 1'h1;
         RT_PORT_I = 5'(p);
         RT_FIRST_I = seed[7:0];
         @(negedge REF_CLK_I);
         RT_REQ_I = 1'h0;
         chk("rt valid", RT_VALID_O, 1);
         chk("rt addr", RT_ADDR_O, STATIC_EN_I[p] ? {3'h0, ctl[p][5:1]} : seed[7:0]);
         chk("rt map", RT_USE_MAP_O, STATIC_EN_I[p] & ctl[p][0]);
      end
      // mid-run reset with a zero strap: defaults return, reload forced to one
      RESET_N_I = 1'h0;
      STRAP_RELOAD_I = 10'h000;
      repeat (2) @(negedge REF_CLK_I);
      RESET_N_I = 1'h1;
      repeat (6) @(negedge REF_CLK_I);
      rd("ctl rst2", ca(7), rv(7));
      rd("rld rst2", 12'h908, 1);
      results;
   end
endmodule

// ===== verilog/router_port_control_two.sv
/*
 Per-port timers, timeout and truncation spill, code filtering and static
 routing of a packet router. Assumes packet state inputs and the tick come
 from logic on REF_CLK_I; link and strap inputs are asynchronous.
*/
`timescale 1ns/100ps
`include "rpc2_defines.svh"
module router_port_control_two #(
   parameter int N = 20,
   parameter int BUF_DEPTH = 2
) (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [11:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   output logic [31:0] REG_RDATA_O,
   output logic REG_ACK_O,
   input wire logic [9:0] STRAP_RELOAD_I,
   input wire logic TICK_I,
   input wire logic [N-1:0] PKT_ACTIVE_I,
   input wire logic [N-1:0] PKT_MOVE_I,
   input wire logic [N-1:0] PKT_OVERRUN_I,
   output logic [N-1:0] SPILL_O,
   input wire logic [N-1:0] STATIC_EN_I,
   input wire logic RT_REQ_I,
   input wire logic [4:0] RT_PORT_I,
   input wire logic [7:0] RT_FIRST_I,
   output logic RT_VALID_O,
   output logic [7:0] RT_ADDR_O,
   output logic RT_USE_MAP_O,
   input wire logic LINK_CLK_I,
   input wire logic [7:0] LINK_CODE_I,
   input wire logic [1:0] LINK_KIND_I,
   input wire logic [4:0] LINK_SRC_I,
   output logic LINK_READY_O,
   output logic CODE_VALID_O,
   input wire logic CODE_READY_I,
   output logic [7:0] CODE_O,
   output logic [1:0] CODE_KIND_O,
   output logic [N-1:0] CODE_DEST_O
);
   localparam int BW = $clog2(BUF_DEPTH);
   localparam int EW = N + 10;

   // returns {hit, index} for a word slot in a block of n registers
   function automatic logic [5:0] slot(input logic [11:0] a, input logic [11:0] base, input int n);
      logic [11:0] off;
      off = a - base;
      slot = {(a >= base) && (off[1:0] == 2'h0) && (off[11:2] < n), off[6:2]};
   endfunction

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   rpc2_pkg::reload_t reload_r [N];
   rpc2_pkg::reload_t reload_nxt [N];
   rpc2_pkg::reload_t tmr_r [N];
   rpc2_pkg::reload_t tmr_nxt [N];
   logic [31:0] ctl_r [N];
   logic [31:0] ctl_nxt [N];
   logic [N-1:0] tmo_flag_r, tmo_flag_nxt, trunc_flag_r, trunc_flag_nxt, spill_nxt;
   logic [N-1:0] to_spill, trunc_hit, or_en, undr_en, ack_tx_en, int_tx_en;
   logic [31:0] rdata_nxt;
   logic [9:0] strap_s1_r, strap_s2_r;
   logic [1:0] strap_cnt_r, strap_cnt_nxt;
   logic [15:0] lnk_s1_r, lnk_s2_r;
   logic lclk_d_r, rise, rx_ok, push, pop;
   logic [EW-1:0] buf_r [BUF_DEPTH];
   logic [EW-1:0] buf_nxt [BUF_DEPTH];
   logic [EW-1:0] entry;
   logic [BW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [BW:0] cnt_r, cnt_nxt;
   logic rt_valid_nxt, rt_map_nxt;
   logic [7:0] rt_addr_nxt;
   logic [5:0] s_tmr, s_ctl, s_sts;
   rpc2_pkg::code_kind_e kind;
   logic [7:0] code;
   logic [4:0] src;
   logic [N-1:0] dest;

   assign s_tmr = slot(REG_ADDR_I, `TMR_BASE, N);
   assign s_ctl = slot(REG_ADDR_I, `CTL2_BASE, N - 1);
   assign s_sts = slot(REG_ADDR_I, `STS_BASE, N);
   assign code = lnk_s2_r[7:0];
   assign kind = rpc2_pkg::code_kind_e'(lnk_s2_r[9:8]);
   assign src = lnk_s2_r[14:10];
   assign rise = lnk_s2_r[15] & ~lclk_d_r;

   // --------------------------------------------------------------
   // per-port decode, timeouts and truncation
   // --------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_port
         assign or_en[g] = ctl_r[g][`OR_BIT];
         assign undr_en[g] = ctl_r[g][`UNDR_BIT];
         assign ack_tx_en[g] = ctl_r[g][`ACK_TX_BIT];
         assign int_tx_en[g] = ctl_r[g][`INT_TX_BIT];
         // expiry only while a packet sits still on the port
         assign to_spill[g] = PKT_ACTIVE_I[g] & ~PKT_MOVE_I[g] & TICK_I & (tmr_r[g] == `RELOAD_MIN) &
            (PKT_OVERRUN_I[g] ? or_en[g] : undr_en[g]);
         // port 0 active means an ongoing config reply
         assign trunc_hit[g] = rise & (kind != rpc2_pkg::CODE_ACK) & PKT_ACTIVE_I[g] &
            (((code ^ ctl_r[g][`MATCH_LSB+:8]) & ctl_r[g][`MASK_LSB+:8]) == 8'h00);
         assign dest[g] = (src != 5'(g)) & ((kind == rpc2_pkg::CODE_ACK) ? ack_tx_en[g] :
            (kind == rpc2_pkg::CODE_INT) ? int_tx_en[g] : 1'b1);
      end
   endgenerate

   // --------------------------------------------------------------
   // registers and timers
   // --------------------------------------------------------------
   always_comb begin
      reload_nxt = reload_r;
      ctl_nxt = ctl_r;
      tmr_nxt = tmr_r;
      strap_cnt_nxt = (strap_cnt_r == 2'h3) ? strap_cnt_r : strap_cnt_r + 2'h1;
      tmo_flag_nxt = tmo_flag_r;
      trunc_flag_nxt = trunc_flag_r;
      rdata_nxt = 32'h0000_0000;
      if (strap_cnt_r == `STRAP_LOAD) begin
         for (int p = 0; p < N; p++) begin
            reload_nxt[p] = (strap_s2_r == 10'h000) ? `RELOAD_MIN : strap_s2_r;
         end
      end
      if (REG_WR_I && s_tmr[5]) begin
         reload_nxt[s_tmr[4:0]] = (REG_WDATA_I[9:0] == 10'h000) ? `RELOAD_MIN : REG_WDATA_I[9:0];
      end
      if (REG_WR_I && REG_ADDR_I == `CFG2_ADDR) begin
         ctl_nxt[0] = REG_WDATA_I & `CFG2_WMASK;
      end
      if (REG_WR_I && s_ctl[5]) begin
         ctl_nxt[s_ctl[4:0] + 5'h01] = REG_WDATA_I & `CTL2_WMASK;
      end
      if (REG_WR_I && s_sts[5]) begin
         tmo_flag_nxt[s_sts[4:0]] = tmo_flag_r[s_sts[4:0]] & ~REG_WDATA_I[`TMO_FLAG_BIT];
         trunc_flag_nxt[s_sts[4:0]] = trunc_flag_r[s_sts[4:0]] & ~REG_WDATA_I[`TRUNC_FLAG_BIT];
      end
      // set after clear so a same-cycle event is kept
      tmo_flag_nxt = tmo_flag_nxt | to_spill;
      trunc_flag_nxt = trunc_flag_nxt | trunc_hit;
      spill_nxt = to_spill | trunc_hit;
      for (int p = 0; p < N; p++) begin
         if (!PKT_ACTIVE_I[p] || PKT_MOVE_I[p] || (TICK_I && tmr_r[p] == `RELOAD_MIN)) begin
            tmr_nxt[p] = reload_r[p];
         end else if (TICK_I) begin
            tmr_nxt[p] = tmr_r[p] - 10'h001;
         end
      end
      if (REG_RD_I) begin
         if (s_tmr[5]) begin
            rdata_nxt[9:0] = reload_r[s_tmr[4:0]];
         end else if (REG_ADDR_I == `CFG2_ADDR) begin
            rdata_nxt = ctl_r[0];
         end else if (s_ctl[5]) begin
            rdata_nxt = ctl_r[s_ctl[4:0] + 5'h01];
         end else if (s_sts[5]) begin
            rdata_nxt[`TMO_FLAG_BIT] = tmo_flag_r[s_sts[4:0]];
            rdata_nxt[`TRUNC_FLAG_BIT] = trunc_flag_r[s_sts[4:0]];
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int p = 0; p < N; p++) begin
            reload_r[p] <= `RELOAD_MIN;
            tmr_r[p] <= `RELOAD_MIN;
            ctl_r[p] <= (p == 0) ? `CFG2_RST : `CTL2_RST;
         end
         strap_cnt_r <= 2'h0;
         tmo_flag_r <= '0;
         trunc_flag_r <= '0;
         SPILL_O <= '0;
         REG_RDATA_O <= 32'h0000_0000;
         REG_ACK_O <= 1'b0;
      end else begin
         reload_r <= reload_nxt;
         tmr_r <= tmr_nxt;
         ctl_r <= ctl_nxt;
         strap_cnt_r <= strap_cnt_nxt;
         tmo_flag_r <= tmo_flag_nxt;
         trunc_flag_r <= trunc_flag_nxt;
         SPILL_O <= spill_nxt;
         REG_RDATA_O <= rdata_nxt;
         REG_ACK_O <= REG_WR_I | REG_RD_I;
      end
   end

   // --------------------------------------------------------------
   // synchronisers
   // --------------------------------------------------------------
   // link clock, source, kind and code ride the same two stages so code stays aligned
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         strap_s1_r <= 10'h000;
         strap_s2_r <= 10'h000;
         lnk_s1_r <= 16'h0000;
         lnk_s2_r <= 16'h0000;
         lclk_d_r <= 1'b0;
      end else begin
         strap_s1_r <= STRAP_RELOAD_I;
         strap_s2_r <= strap_s1_r;
         lnk_s1_r <= {LINK_CLK_I, LINK_SRC_I, LINK_KIND_I, LINK_CODE_I};
         lnk_s2_r <= lnk_s1_r;
         lclk_d_r <= lnk_s2_r[15];
      end
   end

   // --------------------------------------------------------------
   // received code filter and two-entry buffer
   // --------------------------------------------------------------
   always_comb begin
      rx_ok = 1'b1;
      if (src < N) begin
         if (kind == rpc2_pkg::CODE_ACK) begin
            rx_ok = ctl_r[src][`ACK_RX_BIT];
         end else if (kind == rpc2_pkg::CODE_INT) begin
            rx_ok = ctl_r[src][`INT_RX_BIT];
         end
      end
   end

   // a full buffer drops the code; the far end must watch LINK_READY_O
   assign LINK_READY_O = (cnt_r < BUF_DEPTH);
   assign push = rise & rx_ok & LINK_READY_O;
   assign CODE_VALID_O = (cnt_r != '0);
   assign pop = CODE_VALID_O & CODE_READY_I;
   assign entry = buf_r[rp_r];
   assign CODE_O = entry[7:0];
   assign CODE_KIND_O = entry[9:8];
   assign CODE_DEST_O = entry[EW-1:10];

   always_comb begin
      buf_nxt = buf_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         buf_nxt[wp_r] = {dest, kind, code};
         wp_nxt = (wp_r == BW'(BUF_DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = (rp_r == BW'(BUF_DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_r[i] <= '0;
         end
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         buf_r <= buf_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // --------------------------------------------------------------
   // static routing
   // --------------------------------------------------------------
   always_comb begin
      rt_valid_nxt = RT_REQ_I;
      rt_addr_nxt = RT_FIRST_I;
      rt_map_nxt = 1'b0;
      if (RT_PORT_I < N) begin
         if (STATIC_EN_I[RT_PORT_I]) begin
            rt_addr_nxt = {3'h0, ctl_r[RT_PORT_I][`DEST_LSB+:5]};
            rt_map_nxt = ctl_r[RT_PORT_I][`MAP_BIT];
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RT_VALID_O <= 1'b0;
         RT_ADDR_O <= 8'h00;
         RT_USE_MAP_O <= 1'b0;
      end else begin
         RT_VALID_O <= rt_valid_nxt;
         RT_ADDR_O <= rt_addr_nxt;
         RT_USE_MAP_O <= rt_map_nxt;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_zero_reload: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      REG_WR_I && REG_ADDR_I == `TMR_BASE && REG_WDATA_I[9:0] == 10'h000 && strap_cnt_r != `STRAP_LOAD
      |=> reload_r[0] == `RELOAD_MIN) else $error("zero reload not stored as one");
   a_timeout_flag: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      to_spill[3] |=> tmo_flag_r[3] && SPILL_O[3]) else $error("timeout spill not flagged");
   a_trunc_flag: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      trunc_hit[0] |=> trunc_flag_r[0] && SPILL_O[0]) else $error("truncation spill not flagged");
   a_overrun_gate: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      PKT_OVERRUN_I[3] && !ctl_r[3][`OR_BIT] |-> !to_spill[3]) else $error("overrun spill while disabled");
   a_underrun_gate: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      !PKT_OVERRUN_I[0] |-> !to_spill[0]) else $error("config port spilled on underrun");
   a_int_drop: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      rise && kind == rpc2_pkg::CODE_INT && src == 5'h02 && !ctl_r[2][`INT_RX_BIT] |=> cnt_r <= $past(cnt_r))
      else $error("disabled interrupt code accepted");
   a_ack_tx_mask: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      push && kind == rpc2_pkg::CODE_ACK |-> (dest & ~ack_tx_en) == '0) else $error("ack code to disabled port");
   a_static_route: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      RT_REQ_I && RT_PORT_I == 5'h07 && STATIC_EN_I[7]
      |=> RT_VALID_O && RT_ADDR_O == {3'h0, $past(ctl_r[7][`DEST_LSB+:5])}) else $error("static route ignored");
   a_buf_full: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
      cnt_r == (BW + 1)'(BUF_DEPTH) |-> !LINK_READY_O ##0 CODE_VALID_O) else $error("full buffer accepts");
endmodule

// ===== verilog/rpc2_defines.svh
/*
 Register map, field positions and reset values of the per-port
 timeout/filter control block. Assumes byte addresses on a 12-bit window.
*/
// Operation
// - timer reloads from 10-bit reload field
// - written zero reload stores one
// - reload reset value from strap pins
// - config port reply spills on masked match
// - ports 1+ spill packet on masked match
// - config reply overrun spill needs enable
// - ports 1+ overrun spill needs enable
// - underrun spill needs underrun enable
// - ack codes sent only if enabled
// - ack codes dropped if receive disabled
// - interrupt codes sent only if enabled
// - interrupt codes dropped if receive disabled
// - static routing uses static destination field
// - static config bit selects port mapping
// - sticky flag on timeout spill
// - sticky flag on truncation spill
`ifndef RPC2_DEFINES_SVH
`define RPC2_DEFINES_SVH
`define STS_BASE 12'h880
`define TMR_BASE 12'h900
`define CFG2_ADDR 12'h980
`define CTL2_BASE 12'h984
`define CTL2_RST 32'hC000_DE00
`define CFG2_RST 32'hC000_8000
`define CTL2_WMASK 32'hFFFF_DE3F
`define CFG2_WMASK 32'hFFFF_8000
`define RELOAD_MIN 10'h001
`define MASK_LSB 24
`define MATCH_LSB 16
`define OR_BIT 15
`define UNDR_BIT 14
`define ACK_TX_BIT 12
`define ACK_RX_BIT 11
`define INT_TX_BIT 10
`define INT_RX_BIT 9
`define DEST_LSB 1
`define MAP_BIT 0
`define TRUNC_FLAG_BIT 28
`define TMO_FLAG_BIT 18
`define STRAP_LOAD 2'h2
`endif

// ===== verilog/rpc2_pkg.sv
/*
 Types shared by the port control block. Assumes nothing.
*/
package rpc2_pkg;
   typedef enum logic [1:0] {
      CODE_TIME = 2'h0,
      CODE_INT = 2'h1,
      CODE_ACK = 2'h3
   } code_kind_e;
   typedef logic [9:0] reload_t;
endpackage
